//--- hdl/sdx_expander.sv
// Stereo downward expander with register port, lookahead and meter
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// What this block does
// - One gain from the larger of left and right magnitude, applied to both.
// - Expansion only below a threshold of -79.0 to 0.0 dBFS.
// - Ratio 1:1.0 to 1:17.0; 1:1 leaves the signal unchanged.
// - Below threshold the output level slope is the ratio: 2 dB per dB at 1:2.
// - Gain returns over an attack time of 0.0 to 228.0 ms.
// - Gain drops over a release time of 0 to 3000 ms.
// - Control gain is lowpass smoothed with 0.0 to 228.0 ms time.
// - Main path lags detection by a lookahead of 0.0 to 25.0 ms.
// - Active setting processes audio; bypass passes input unprocessed.
// - Output trim is ignored while bypassed.
// - Output trim -79.0 to 24.0 dB, plus Off which mutes.
// - Trim and added boost add in dB, total boost capped at 24 dB.
// - Gain reduction is reported as a meter from 0 to 40 dB.
module sdx_expander (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_ce,
  input  wire logic [sdx_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [sdx_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic      [sdx_pkg::DATA_W-1:0]  o_rdata,
  input  wire logic                        i_in_valid,
  input  wire sdx_pkg::sdx_frame_type      i_in,
  output logic                             o_out_valid,
  output sdx_pkg::sdx_frame_type           o_out
);

  // Gain mantissa 2^(f/16), unsigned Q1.15
  localparam logic [15:0] MANT [16] = '{
    16'h8000, 16'h85AB, 16'h8B96, 16'h91C4, 16'h9838, 16'h9EF5,
    16'hA5FF, 16'hAD58, 16'hB505, 16'hBD09, 16'hC567, 16'hCE25,
    16'hD745, 16'hE0CD, 16'hEAC1, 16'hF525};

  logic [15:0] ctrl_r, ratio_r, atk_r, rel_r, smo_r, dly_r;
  logic signed [15:0] thr_r, trim_r, boost_r;
  logic [15:0] rdata_r;
  logic [7:0]  env_r, meter_r;
  logic [11:0] cnt_r;
  logic [23:0] sm_r;
  logic [10:0] wp_r;
  sdx_pkg::sdx_frame_type mem [sdx_pkg::DLY_DEPTH];
  sdx_pkg::sdx_frame_type out_r;
  logic                   out_vld_r;

  // Position of the leading one, zero for zero
  function automatic logic [3:0] lead_one(input logic [15:0] v);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        p = 4'(i);
      end
    end
    return p;
  endfunction

  // Log2 of a magnitude in 1/16 octave steps
  function automatic logic [7:0] log2u(input logic [15:0] m);
    logic [3:0]  p;
    logic [15:0] n;
    p = lead_one(m);
    n = m << (4'd15 - p);
    return {p, n[14:11]};
  endfunction

  function automatic logic [15:0] mag(input logic signed [15:0] x);
    return x[15] ? 16'(-x) : 16'(x);
  endfunction

  // Apply 2^((e-64)/16) with saturation
  function automatic logic signed [15:0] apply_gain(
    input logic signed [15:0] x,
    input logic [2:0]         ip,
    input logic [3:0]         fp);
    logic signed [32:0] p;
    logic signed [39:0] y;
    p = x * $signed({1'b0, MANT[fp]});
    // Widen before the shift; a 33-bit shift loses the top of loud samples
    y = 40'(p);
    y = (y <<< ip) >>> 19;
    if (y > 40'sd32767) begin
      return 16'sh7FFF;
    end else if (y < -40'sd32768) begin
      return 16'sh8000;
    end
    return y[15:0];
  endfunction

  function automatic logic signed [15:0] clamp_s(
    input logic signed [15:0] v,
    input logic signed [15:0] lo,
    input logic signed [15:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [15:0] clamp_u(input logic [15:0] v,
                                          input logic [15:0] hi);
    return (v > hi) ? hi : v;
  endfunction

  // Register writes; control keeps only bits 2:0, other values outside the legal range are pinned to the edge
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_r  <= sdx_pkg::CTRL_RST;
      ratio_r <= sdx_pkg::RATIO_RST;
      thr_r   <= sdx_pkg::THRESH_RST;
      atk_r   <= sdx_pkg::ATTACK_RST;
      rel_r   <= sdx_pkg::RELEASE_RST;
      smo_r   <= sdx_pkg::SMOOTH_RST;
      dly_r   <= sdx_pkg::DELAY_RST;
      trim_r  <= sdx_pkg::GAIN_RST;
      boost_r <= sdx_pkg::GAIN_RST;
    end else if (i_ce && i_wr) begin
      unique case (i_addr)
        sdx_pkg::REG_CTRL:    ctrl_r  <= {13'h0, i_wdata[2:0]};
        sdx_pkg::REG_RATIO:   ratio_r <= (i_wdata < sdx_pkg::RATIO_MIN) ?
            sdx_pkg::RATIO_MIN : clamp_u(i_wdata, sdx_pkg::RATIO_MAX);
        sdx_pkg::REG_THRESH:  thr_r   <= clamp_s(i_wdata,
            sdx_pkg::THR_MIN, sdx_pkg::THR_MAX);
        sdx_pkg::REG_ATTACK:  atk_r   <= clamp_u(i_wdata, sdx_pkg::ATK_MAX);
        sdx_pkg::REG_RELEASE: rel_r   <= clamp_u(i_wdata, sdx_pkg::REL_MAX);
        sdx_pkg::REG_SMOOTH:  smo_r   <= clamp_u(i_wdata, sdx_pkg::SMO_MAX);
        sdx_pkg::REG_DELAY:   dly_r   <= clamp_u(i_wdata, sdx_pkg::DLY_MAX);
        sdx_pkg::REG_TRIM:    trim_r  <= clamp_s(i_wdata,
            sdx_pkg::GAIN_MIN, sdx_pkg::GAIN_MAX);
        sdx_pkg::REG_BOOST:   boost_r <= clamp_s(i_wdata,
            sdx_pkg::GAIN_MIN, sdx_pkg::GAIN_MAX);
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_r <= 16'h0000;
    end else if (i_ce) begin
      rdata_r <= 16'h0000;
      if (i_rd) begin
        unique case (i_addr)
          sdx_pkg::REG_CTRL:    rdata_r <= ctrl_r;
          sdx_pkg::REG_RATIO:   rdata_r <= ratio_r;
          sdx_pkg::REG_THRESH:  rdata_r <= thr_r;
          sdx_pkg::REG_ATTACK:  rdata_r <= atk_r;
          sdx_pkg::REG_RELEASE: rdata_r <= rel_r;
          sdx_pkg::REG_SMOOTH:  rdata_r <= smo_r;
          sdx_pkg::REG_DELAY:   rdata_r <= dly_r;
          sdx_pkg::REG_TRIM:    rdata_r <= trim_r;
          sdx_pkg::REG_BOOST:   rdata_r <= boost_r;
          sdx_pkg::REG_METER:   rdata_r <= {8'h00, meter_r};
          default:              rdata_r <= 16'h0000;
        endcase
      end
    end
  end
  assign o_rdata = rdata_r;

  logic               active, trim_off, boost_off;
  logic [7:0]         lvl_log;
  logic signed [10:0] lvl_rel, thr_u, diff;
  logic [7:0]         ratio_m;
  logic [23:0]        gr_raw;
  logic [7:0]         tgt;
  logic [11:0]        atk_n, rel_n;
  logic [10:0]        dly_n;
  logic [3:0]         smo_k;

  assign active    = ctrl_r[sdx_pkg::CTRL_ACTIVE_BIT];
  assign trim_off  = ctrl_r[sdx_pkg::CTRL_TRIM_OFF_BIT];
  assign boost_off = ctrl_r[sdx_pkg::CTRL_BOOST_OFF];

  // Linked detector: larger magnitude of the pair drives one level
  assign lvl_log = log2u((mag(i_in.left) > mag(i_in.right)) ?
                         mag(i_in.left) : mag(i_in.right));
  assign lvl_rel = 11'($signed({3'b000, lvl_log})) - sdx_pkg::LVL_FS;
  // Tenths of dB to 1/16 octave: x*17/64 is within 0.2 percent
  assign thr_u   = 11'((32'(thr_r) * 17) >>> 6);
  assign diff    = thr_u - lvl_rel;
  assign ratio_m = 8'(ratio_r - sdx_pkg::RATIO_MIN);

  // Target reduction is depth below threshold times (ratio-1); the 205/2048
  // scale removes the tenths of the ratio setting
  always_comb begin
    gr_raw = 24'h000000;
    if (diff > 11'sd0) begin
      gr_raw = 24'((32'(diff) * 32'(ratio_m) * 205) >> 11);
    end
  end
  assign tgt = (gr_raw > 24'd255) ? 8'hFF : gr_raw[7:0];

  // Step periods: attack and release each span a 24 dB (64 step) swing
  assign atk_n = 12'((32'(atk_r) * 77) >> 10);
  assign rel_n = 12'((32'(rel_r) * 3) >> 2);
  assign dly_n = 11'((32'(dly_r) * 1229) >> 8);
  assign smo_k = lead_one(16'((32'(smo_r) * 77) >> 4));

  // Envelope ramps toward the target, one step per period
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      env_r <= 8'h00;
      cnt_r <= 12'h000;
    end else if (i_ce && i_in_valid) begin
      if (tgt < env_r) begin
        if (cnt_r >= atk_n) begin
          env_r <= (atk_n == 12'h000) ? tgt : 8'(env_r - 8'h01);
          cnt_r <= 12'h000;
        end else begin
          cnt_r <= 12'(cnt_r + 12'h001);
        end
      end else if (tgt > env_r) begin
        if (cnt_r >= rel_n) begin
          env_r <= (rel_n == 12'h000) ? tgt : 8'(env_r + 8'h01);
          cnt_r <= 12'h000;
        end else begin
          cnt_r <= 12'(cnt_r + 12'h001);
        end
      end else begin
        cnt_r <= 12'h000;
      end
    end
  end

  // One-pole lowpass on the control path; 16 fraction bits keep the long
  // settings from stalling short of the envelope
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sm_r <= 24'h000000;
    end else if (i_ce && i_in_valid) begin
      sm_r <= 24'($signed({1'b0, sm_r}) +
              (($signed({1'b0, env_r, 16'h0000}) -
                $signed({1'b0, sm_r})) >>> smo_k));
    end
  end

  // Meter in whole dB; 385/1024 converts 1/16 octave to dB
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meter_r <= 8'h00;
    end else if (i_ce) begin
      meter_r <= (((32'(sm_r[23:16]) * 385) >> 10) > 32'(sdx_pkg::METER_MAX))
                 ? sdx_pkg::METER_MAX
                 : 8'((32'(sm_r[23:16]) * 385) >> 10);
    end
  end

  // Lookahead line; the memory keeps no reset so it maps to RAM
  always_ff @(posedge i_clk) begin
    if (i_ce && i_in_valid) begin
      mem[wp_r] <= i_in;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wp_r <= 11'h000;
    end else if (i_ce && i_in_valid) begin
      wp_r <= 11'(wp_r + 11'h001);
    end
  end

  sdx_pkg::sdx_frame_type dly_smp;
  logic signed [15:0]     tot_t;
  logic signed [10:0]     tot_u, e_val;
  logic                   mute;

  assign dly_smp = (dly_n == 11'h000) ? i_in : mem[11'(wp_r - dly_n)];

  // Trim and boost add in dB, capped at the boost ceiling
  assign tot_t = (16'(trim_r + boost_r) > sdx_pkg::BOOST_CAP) ?
                 sdx_pkg::BOOST_CAP : 16'(trim_r + boost_r);
  assign tot_u = 11'((32'(tot_t) * 17) >>> 6);
  assign e_val = sdx_pkg::UNITY_E - $signed({3'b000, sm_r[23:16]}) + tot_u;
  assign mute  = trim_off || boost_off || (e_val < 11'sd0);

  // Output stage; bypass passes the raw input and never sees the trim
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      out_r     <= '0;
      out_vld_r <= 1'b0;
    end else if (i_ce) begin
      out_vld_r <= i_in_valid;
      if (i_in_valid) begin
        if (!active) begin
          out_r <= i_in;
        end else if (mute) begin
          out_r <= '0;
        end else begin
          out_r.left  <= apply_gain(dly_smp.left, e_val[6:4], e_val[3:0]);
          out_r.right <= apply_gain(dly_smp.right, e_val[6:4], e_val[3:0]);
        end
      end
    end
  end
  assign o_out   = out_r;
  assign o_out_valid = out_vld_r;

  // Checks on the block's own behaviour
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_bypass_pass_through: assert property (
    i_ce && i_in_valid && !active |=> o_out == $past(i_in))
    else $error("bypass output differs from input");
  a_bypass_trim_ignored: assert property (
    i_ce && i_in_valid && !active && trim_off |=> o_out == $past(i_in))
    else $error("trim affected bypassed signal");
  a_linked_gain: assert property (
    i_ce && i_in_valid && active && dly_n == 11'h000 &&
    i_in.left == i_in.right |=> o_out.left == o_out.right)
    else $error("channels got different gain");
  a_no_exp_above: assert property (
    lvl_rel >= thr_u |-> tgt == 8'h00)
    else $error("reduction above threshold");
  a_unity_ratio: assert property (
    ratio_r == sdx_pkg::RATIO_MIN |-> tgt == 8'h00)
    else $error("1:1 ratio changed the gain");
  a_slope_below: assert property (
    diff >= 11'sd4 && ratio_m >= 8'd10 |-> tgt >= 8'(diff >> 2))
    else $error("expansion slope too shallow");
  a_attack_step: assert property (
    i_ce && i_in_valid && tgt < env_r && atk_n == 12'h000
    |=> env_r == $past(tgt))
    else $error("instant attack missed");
  a_release_step: assert property (
    i_ce && i_in_valid && tgt > env_r && rel_n != 12'h000
    |=> env_r <= 8'($past(env_r) + 8'h01) && env_r >= $past(env_r))
    else $error("release stepped too far");
  a_smooth_bound: assert property (
    smo_k == 4'h0 && i_ce && i_in_valid
    |=> sm_r == {$past(env_r), 16'h0000})
    else $error("zero smoothing did not track");
  a_lookahead_len: assert property (
    dly_n <= 11'd1200)
    else $error("lookahead beyond range");
  a_off_mutes: assert property (
    i_ce && i_in_valid && active && trim_off |=> o_out == '0)
    else $error("off did not mute");
  a_boost_capped: assert property (
    tot_t <= sdx_pkg::BOOST_CAP)
    else $error("combined boost over cap");
  a_meter_range: assert property (
    meter_r <= sdx_pkg::METER_MAX)
    else $error("meter out of range");

  c_bypass: cover property (i_ce && i_in_valid && !active);
  c_expanding: cover property (i_ce && i_in_valid && active && tgt > 8'h00);
  c_meter_full: cover property (meter_r == sdx_pkg::METER_MAX);
  c_muted: cover property (i_ce && i_in_valid && active && mute);

endmodule

//--- pkg/sdx_pkg.sv
// Shared constants and types for the stereo downward expander
package sdx_pkg;

  // Sample stream
  localparam int SMP_W   = 16;
  localparam int CLK_HZ  = 20_000_000;
  localparam int SMP_HZ  = 48_000;

  typedef struct packed {
    logic signed [SMP_W-1:0] left;
    logic signed [SMP_W-1:0] right;
  } sdx_frame_type;

  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register indices
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_RATIO   = 4'h1;
  localparam logic [3:0] REG_THRESH  = 4'h2;
  localparam logic [3:0] REG_ATTACK  = 4'h3;
  localparam logic [3:0] REG_RELEASE = 4'h4;
  localparam logic [3:0] REG_SMOOTH  = 4'h5;
  localparam logic [3:0] REG_DELAY   = 4'h6;
  localparam logic [3:0] REG_TRIM    = 4'h7;
  localparam logic [3:0] REG_BOOST   = 4'h8;
  localparam logic [3:0] REG_METER   = 4'h9;

  // Control bit positions
  localparam int CTRL_ACTIVE_BIT   = 0;
  localparam int CTRL_TRIM_OFF_BIT = 1;
  localparam int CTRL_BOOST_OFF    = 2;

  // Ranges, tenths of dB, tenths of ms, or ms for release
  localparam logic signed [15:0] THR_MIN   = -16'sd790;
  localparam logic signed [15:0] THR_MAX   = 16'sd0;
  localparam logic [15:0]        RATIO_MIN = 16'd10;
  localparam logic [15:0]        RATIO_MAX = 16'd170;
  localparam logic [15:0]        ATK_MAX   = 16'd2280;
  localparam logic [15:0]        REL_MAX   = 16'd3000;
  localparam logic [15:0]        SMO_MAX   = 16'd2280;
  localparam logic [15:0]        DLY_MAX   = 16'd250;
  localparam logic signed [15:0] GAIN_MIN  = -16'sd790;
  localparam logic signed [15:0] GAIN_MAX  = 16'sd240;
  localparam logic signed [15:0] BOOST_CAP = 16'sd240;
  localparam logic [7:0]         METER_MAX = 8'd40;

  // Reset values
  localparam logic [15:0] CTRL_RST    = 16'h0000;
  localparam logic [15:0] RATIO_RST   = 16'd10;
  localparam logic [15:0] THRESH_RST  = 16'hFE0C; // -50.0 dB
  localparam logic [15:0] ATTACK_RST  = 16'd10;
  localparam logic [15:0] RELEASE_RST = 16'd200;
  localparam logic [15:0] SMOOTH_RST  = 16'd0;
  localparam logic [15:0] DELAY_RST   = 16'd0;
  localparam logic [15:0] GAIN_RST    = 16'd0;

  // Internal level unit is 1/16 octave; full scale sits at this code
  localparam logic signed [10:0] LVL_FS  = 11'sd240;
  localparam logic signed [10:0] UNITY_E = 11'sd64;
  localparam int DLY_DEPTH = 2048;
endpackage

//--- verif/sdx_stream_model.sv
// Stereo sample source and sink facing the expander stream port
`timescale 1ns/1ps
module sdx_stream_model (
  input  wire logic                   i_clk,
  output logic                        o_valid,
  output sdx_pkg::sdx_frame_type      o_frame,
  input  wire logic                   i_out_valid,
  input  wire sdx_pkg::sdx_frame_type i_out
);
  sdx_pkg::sdx_frame_type last_r;
  int                     late_cnt;

  // Idle source at time zero
  initial begin
    o_valid  = 1'b0;
    o_frame  = '0;
    late_cnt = 0;
  end

  // One stereo frame per strobe, left and right always together; data
  // lines scramble outside the strobe so a late sampler sees garbage
  task automatic send(input logic [15:0] l, input logic [15:0] r,
                      input int gap);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_frame <= {l, r};
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_frame <= ~{l, r};
    #1;
    if (i_out_valid !== 1'b1) late_cnt++;
    last_r = i_out;
    repeat (gap) @(posedge i_clk);
  endtask
endmodule

//--- verif/stereo_downward_expander_tb.sv
// Self-checking bench for the stereo downward expander
`timescale 1ns/1ps
module stereo_downward_expander_tb;
  logic                   i_clk;
  logic                   i_rst_n;
  logic                   ce;
  logic [3:0]             addr;
  logic [15:0]            wdata;
  logic                   wr;
  logic                   rd;
  logic [15:0]            rdata;
  logic                   in_valid;
  logic                   out_valid;
  sdx_pkg::sdx_frame_type in_frame;
  sdx_pkg::sdx_frame_type out_frame;
  logic [15:0]            rv;
  logic [15:0]            found;
  int                     failures;
  int                     checks;
  logic [15:0]            rst_tab [10];
  logic [15:0]            clp_tab [11][3];

  sdx_expander uut (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_ce        (ce),
    .i_addr      (addr),
    .i_wdata     (wdata),
    .i_wr        (wr),
    .i_rd        (rd),
    .o_rdata     (rdata),
    .i_in_valid  (in_valid),
    .i_in        (in_frame),
    .o_out_valid (out_valid),
    .o_out       (out_frame)
  );

  sdx_stream_model src (
    .i_clk       (i_clk),
    .o_valid     (in_valid),
    .o_frame     (in_frame),
    .i_out_valid (out_valid),
    .i_out       (out_frame)
  );

  // 20 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // Reset held 12 cycles; also used mid-run to restore defaults
  task automatic do_reset;
    i_rst_n <= 1'b0;
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
  endtask

  // Register write, one strobe cycle
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask

  // Register read; data valid only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a);
    @(posedge i_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge i_clk);
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask

  task automatic cmp16(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Gain maths is approximate, so levels are checked within a band
  task automatic cmprng(input string what, input int lo, input int hi,
                        input logic signed [15:0] got);
    logic ok;
    checks++;
    ok = (got >= lo) && (got <= hi);
    if (ok !== 1'b1) begin
      failures++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic burst(input logic [15:0] l, input logic [15:0] r,
                       input int n);
    repeat (n) src.send(l, r, 1);
  endtask

  task automatic tend(input string name);
    $display("Test %s done", name);
  endtask

  task automatic results;
    $display("Checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #(50 * 40000);
    failures++;
    results();
  end

  // Main sequence
  initial begin
    i_rst_n = 1'b0;
    ce      = 1'b1;
    addr    = 4'h0;
    wdata   = 16'h0000;
    wr      = 1'b0;
    rd      = 1'b0;
    failures = 0;
    checks   = 0;
    rst_tab = '{16'h0000, 16'h000A, 16'hFE0C, 16'h000A, 16'h00C8,
                16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    clp_tab = '{'{16'h1, 16'h0005, 16'h000A}, '{16'h1, 16'h00C8, 16'h00AA},
                '{16'h2, 16'h0064, 16'h0000}, '{16'h2, 16'hFC00, 16'hFCEA},
                '{16'h3, 16'h2710, 16'h08E8}, '{16'h4, 16'h1388, 16'h0BB8},
                '{16'h5, 16'h2710, 16'h08E8}, '{16'h6, 16'h03E7, 16'h00FA},
                '{16'h7, 16'h01F4, 16'h00F0}, '{16'h8, 16'h01F4, 16'h00F0},
                '{16'h9, 16'h0015, 16'h0000}};
    do_reset();
    for (int i = 0; i < 10; i++) begin
      rreg(i[3:0]);
      cmp16("reset value", rst_tab[i], rv);
    end
    // Out-of-range writes clamp; meter and unmapped space stay zero
    foreach (clp_tab[i]) begin
      wreg(clp_tab[i][0][3:0], clp_tab[i][1]);
      rreg(clp_tab[i][0][3:0]);
      cmp16("clamp", clp_tab[i][2], rv);
    end
    rreg(4'hC);
    cmp16("unmapped", 16'h0000, rv);
    // Clock enable low must drop a write; ratio keeps its clamped 1:17
    @(posedge i_clk);
    ce <= 1'b0;
    wreg(4'h1, 16'h0014);
    ce <= 1'b1;
    rreg(4'h1);
    cmp16("frozen write", 16'h00AA, rv);
    tend("registers");
    // Bypass ignores a low trim and trim Off alike
    do_reset();
    wreg(4'h7, 16'hFF38);
    wreg(4'h0, 16'h0002);
    src.send(16'h04D2, 16'hEF1F, 1);
    cmp16("bypass left", 16'h04D2, src.last_r.left);
    cmp16("bypass right", 16'hEF1F, src.last_r.right);
    tend("bypass");
    // Active at 1:1 leaves the level alone; trim back to 0 dB first
    wreg(4'h7, 16'h0000);
    wreg(4'h0, 16'h0001);
    burst(16'h0BB8, 16'hF448, 4);
    cmprng("unity left", 2900, 3100, src.last_r.left);
    cmprng("unity right", -3100, -2900, src.last_r.right);
    // Either Off setting mutes
    wreg(4'h0, 16'h0003);
    src.send(16'h0BB8, 16'hF448, 1);
    cmp16("trim off", 16'h0000, src.last_r[15:0]);
    wreg(4'h0, 16'h0005);
    src.send(16'h0BB8, 16'hF448, 1);
    cmp16("boost off", 16'h0000, src.last_r[31:16]);
    // Trim and boost add but stop at +24 dB
    wreg(4'h0, 16'h0001);
    wreg(4'h7, 16'h00F0);
    wreg(4'h8, 16'h00F0);
    burst(16'h03E8, 16'hFC18, 3);
    cmprng("boost cap", 14500, 17300, src.last_r.left);
    wreg(4'h7, 16'hFFC4);
    wreg(4'h8, 16'h0000);
    burst(16'h03E8, 16'hFC18, 3);
    cmprng("trim -6dB", 460, 545, src.last_r.left);
    tend("gain");
    // Linked detection: a loud right keeps a quiet left unexpanded
    do_reset();
    wreg(4'h0, 16'h0001);
    wreg(4'h3, 16'h0000);
    wreg(4'h4, 16'h0000);
    wreg(4'h2, 16'hFF38);
    wreg(4'h1, 16'h0014);
    burst(16'h0064, 16'h7530, 4);
    cmprng("linked", 95, 105, src.last_r.left);
    // 6 dB under threshold at 1:2 gives 6 dB of cut
    burst(16'h0666, 16'h0666, 4);
    cmprng("slope", 740, 900, src.last_r.left);
    cmprng("slope r", 740, 900, src.last_r.right);
    rreg(4'h9);
    cmprng("meter", 5, 7, rv);
    wreg(4'h1, 16'h00AA);
    burst(16'h0666, 16'h0666, 2);
    rreg(4'h9);
    cmp16("meter clamp", 16'h0028, rv);
    // Slow release barely moves in a few samples
    wreg(4'h1, 16'h0014);
    burst(16'h7530, 16'h7530, 2);
    wreg(4'h4, 16'h0BB8);
    burst(16'h0666, 16'h0666, 5);
    rreg(4'h9);
    cmprng("release", 0, 1, rv);
    wreg(4'h4, 16'h0000);
    burst(16'h0666, 16'h0666, 3);
    wreg(4'h3, 16'h08E8);
    burst(16'h7530, 16'h7530, 3);
    rreg(4'h9);
    cmprng("attack", 5, 7, rv);
    wreg(4'h3, 16'h0000);
    wreg(4'h5, 16'h08E8);
    burst(16'h7530, 16'h7530, 3);
    rreg(4'h9);
    cmprng("smoothing", 5, 7, rv);
    tend("dynamics");
    // Lookahead of 1.0 ms is 48 samples; memory is primed with zeros
    do_reset();
    wreg(4'h0, 16'h0001);
    burst(16'h0000, 16'h0000, 60);
    wreg(4'h6, 16'h000A);
    found = 16'hFFFF;
    for (int k = 0; k < 52; k++) begin
      src.send((k == 0) ? 16'h1F40 : 16'h0000, 16'h0000, 1);
      if (src.last_r.left !== 16'h0000 && found === 16'hFFFF) found = 16'(k);
    end
    cmp16("lookahead", 16'h0030, found);
    cmp16("out strobe", 16'h0000, src.late_cnt[15:0]);
    tend("lookahead");
    results();
  end
endmodule
